/* sixcfg_regs.v */
// Configuration registers for the sixth analog input channel.
// Assumes a synchronous byte register port already decoded from I2C or SPI.
// Summary of operation
// - Bit 7 of the input config register picks microphone (0) or line (1) input.
// - Bits 6 to 5 pick differential (0) or single-ended (1) input, code 2 reserved.
// - Bit 4 picks AC (0) or DC (1) coupling and resets to DC.
// - Bit 3 picks low swing (0) or high swing (1) microphone range.
// - Bits 2 to 1 pick high SNR (0) or high CMRR (2) mode, codes 1 and 3 reserved.
// - Bit 0 enables automatic gain control, run per the global AGC config bit.
// - Gain bits 7 to 2 set 0 to 42 dB in 1 dB steps, codes 43 to 63 reserved.
// - Gain register sits at page 0 address 0x56, resets to zero, bit 1 reserved RW, bit 0 reserved RO.
// - Volume code 0 mutes, code 1 is -100 dB, 0.5 dB per code, 201 is 0 dB, 255 is 27 dB.
// - Volume register sits at page 0 address 0x57 and resets to C9h.
`include "sixcfg_map.vh"

module sixcfg_regs #(
    parameter CHANNEL_PRESENT = 1
) (
    input  wire       core_clk,
    input  wire       arst_n,
    input  wire [7:0] regPage,
    input  wire [7:0] regAddr,
    input  wire       regWrite,
    input  wire       regRead,
    input  wire [7:0] regWdata,
    input  wire       agcGlobalMode,
    output reg  [7:0] regRdata,
    output reg        regHit,
    output reg        sixthInputKind,
    output reg  [1:0] sixthInputForm,
    output reg        sixthInputCoupling,
    output reg        sixthMicSwingRange,
    output reg  [1:0] sixthAmpPerfMode,
    output reg        sixthAutoGainEnable,
    output reg        sixthAgcMode,
    output reg  [5:0] sixthAnalogGain,
    output reg  [7:0] sixthDigitalVolume,
    output reg        sixthMuted
);

    // Output copies leave reset with the same values as the stored registers
    localparam [7:0] CFG_RESET  = `SIXCFG_INCFG_RESET;
    localparam [7:0] GAIN_RESET = `SIXCFG_GAIN_RESET;
    localparam [7:0] VOL_RESET  = `SIXCFG_VOL_RESET;

    reg        rstMeta;
    reg        rstSync;
    reg  [7:0] inputConfig;
    reg  [7:0] gainReg;
    reg  [7:0] volumeReg;
    reg  [7:0] next_inputConfig;
    reg  [7:0] next_gainReg;
    reg  [7:0] next_volumeReg;
    reg  [7:0] next_rdata;
    reg        next_hit;
    wire       selConfig;
    wire       selGain;
    wire       selVolume;

    // Address match on page zero; absent channel decodes nothing
    function addrHit;
        input [7:0] page;
        input [7:0] addr;
        input [7:0] target;
        begin
            addrHit = (CHANNEL_PRESENT != 0) && (page == `SIXCFG_PAGE) && (addr == target);
        end
    endfunction

    // Reset release through two flops to avoid metastable release
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // One decode per register, shared by the write and the read paths
    assign selConfig = addrHit(regPage, regAddr, `SIXCFG_INCFG_ADDR);
    assign selGain   = addrHit(regPage, regAddr, `SIXCFG_GAIN_ADDR);
    assign selVolume = addrHit(regPage, regAddr, `SIXCFG_VOL_ADDR);

    // Next register values; reserved codes are stored as written, software must avoid them
    always @* begin
        next_inputConfig = inputConfig;
        next_gainReg     = gainReg;
        next_volumeReg   = volumeReg;
        if (regWrite && selConfig) begin
            next_inputConfig = regWdata;
        end else if (regWrite && selGain) begin
            // Bit 0 is read-only zero, so a written one is never stored
            next_gainReg = {regWdata[7:1], 1'h0};
        end else if (regWrite && selVolume) begin
            next_volumeReg = regWdata;
        end
    end

    // Input configuration store; leaves reset DC-coupled
    always @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            inputConfig <= CFG_RESET;
        end else begin
            inputConfig <= next_inputConfig;
        end
    end

    // Analog gain store
    always @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            gainReg <= GAIN_RESET;
        end else begin
            gainReg <= next_gainReg;
        end
    end

    // Digital volume store; leaves reset at unity
    always @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            volumeReg <= VOL_RESET;
        end else begin
            volumeReg <= next_volumeReg;
        end
    end

    // Read mux; unmapped addresses read zero and drop the hit flag
    always @* begin
        next_rdata = 8'h00;
        next_hit   = 1'b0;
        if (selConfig) begin
            next_rdata = inputConfig;
            next_hit   = 1'b1;
        end else if (selGain) begin
            next_rdata = gainReg;
            next_hit   = 1'b1;
        end else if (selVolume) begin
            next_rdata = volumeReg;
            next_hit   = 1'b1;
        end
    end

    // Hit flag stands for one cycle after a read of a mapped address
    always @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            regHit <= 1'h0;
        end else begin
            regHit <= regRead & next_hit;
        end
    end

    // Read data registered; held until the next read so a slow host can still pick it up
    always @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= next_rdata;
        end
    end

    // Input kind and form; one flop behind the store so every pin comes from a flop
    always @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            sixthInputKind <= CFG_RESET[`SIXCFG_KIND_BIT];
            sixthInputForm <= CFG_RESET[`SIXCFG_FORM_HI:`SIXCFG_FORM_LO];
        end else begin
            sixthInputKind <= inputConfig[`SIXCFG_KIND_BIT];
            sixthInputForm <= inputConfig[`SIXCFG_FORM_HI:`SIXCFG_FORM_LO];
        end
    end

    // Coupling and microphone swing range
    always @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            sixthInputCoupling <= CFG_RESET[`SIXCFG_COUPLING_BIT];
            sixthMicSwingRange <= CFG_RESET[`SIXCFG_SWING_BIT];
        end else begin
            sixthInputCoupling <= inputConfig[`SIXCFG_COUPLING_BIT];
            sixthMicSwingRange <= inputConfig[`SIXCFG_SWING_BIT];
        end
    end

    // Amplifier performance mode; reserved codes pass through unchanged
    always @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            sixthAmpPerfMode <= CFG_RESET[`SIXCFG_PERF_HI:`SIXCFG_PERF_LO];
        end else begin
            sixthAmpPerfMode <= inputConfig[`SIXCFG_PERF_HI:`SIXCFG_PERF_LO];
        end
    end

    // Automatic gain control enable and the mode it runs in
    always @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            sixthAutoGainEnable <= CFG_RESET[`SIXCFG_AGC_BIT];
            sixthAgcMode        <= 1'h0;
        end else begin
            sixthAutoGainEnable <= inputConfig[`SIXCFG_AGC_BIT];
            // Mode is only meaningful while enabled; reads low when off
            sixthAgcMode        <= inputConfig[`SIXCFG_AGC_BIT] & agcGlobalMode;
        end
    end

    // Analog gain code; codes above the top step pass through unchanged
    always @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            sixthAnalogGain <= GAIN_RESET[`SIXCFG_GAIN_HI:`SIXCFG_GAIN_LO];
        end else begin
            sixthAnalogGain <= gainReg[`SIXCFG_GAIN_HI:`SIXCFG_GAIN_LO];
        end
    end

    // Digital volume code and mute flag
    always @(posedge core_clk or negedge rstSync) begin
        if (!rstSync) begin
            sixthDigitalVolume <= VOL_RESET;
            sixthMuted         <= (VOL_RESET == `SIXCFG_VOL_MUTE);
        end else begin
            sixthDigitalVolume <= volumeReg;
            sixthMuted         <= (volumeReg == `SIXCFG_VOL_MUTE);
        end
    end

endmodule

/* sixcfg_map.vh */
// Register map constants for the sixth channel configuration group.
// Assumes a byte-wide register port addressed on page zero.
`ifndef SIXCFG_MAP_VH
`define SIXCFG_MAP_VH
`define SIXCFG_PAGE            8'h00
`define SIXCFG_INCFG_ADDR      8'h55
`define SIXCFG_GAIN_ADDR       8'h56
`define SIXCFG_VOL_ADDR        8'h57
`define SIXCFG_INCFG_RESET     8'h10
`define SIXCFG_GAIN_RESET      8'h00
`define SIXCFG_VOL_RESET       8'hC9
`define SIXCFG_KIND_BIT        7
`define SIXCFG_FORM_HI         6
`define SIXCFG_FORM_LO         5
`define SIXCFG_COUPLING_BIT    4
`define SIXCFG_SWING_BIT       3
`define SIXCFG_PERF_HI         2
`define SIXCFG_PERF_LO         1
`define SIXCFG_AGC_BIT         0
`define SIXCFG_GAIN_HI         7
`define SIXCFG_GAIN_LO         2
`define SIXCFG_GAIN_RSVRW_BIT  1
`define SIXCFG_GAIN_MAX        6'h2A
`define SIXCFG_VOL_MUTE        8'h00
`define SIXCFG_VOL_UNITY       8'hC9
`endif

/* sixcfg_regs_assertions.sv */
// Checker for the sixth channel register group, bound to every sixcfg_regs.
// Assumes no access before the third edge after reset release.
module sixcfg_chk (
    input logic       core_clk, arst_n, regWrite, regRead, agcGlobalMode, regHit, sixthMuted,
    input logic       sixthInputKind, sixthInputCoupling, sixthMicSwingRange, sixthAutoGainEnable, sixthAgcMode,
    input logic [1:0] sixthInputForm, sixthAmpPerfMode,
    input logic [5:0] sixthAnalogGain,
    input logic [7:0] regPage, regAddr, regWdata, regRdata, sixthDigitalVolume
);
    timeunit 1ns;
    timeprecision 1ps;
    // Only page zero decodes; everything else must stay silent
    wire wr0 = regWrite && regPage == 8'h00;
    wire map = regPage == 8'h00 && regAddr inside {8'h55, 8'h56, 8'h57};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_config_write: assert property (wr0 && regAddr == 8'h55 |-> ##2 $past(regWdata, 2) == {sixthInputKind,
        sixthInputForm, sixthInputCoupling, sixthMicSwingRange, sixthAmpPerfMode, sixthAutoGainEnable}) else $error("config field wrong");
    a_gain_write: assert property (wr0 && regAddr == 8'h56 |-> ##2 sixthAnalogGain == $past(regWdata[7:2], 2))
        else $error("gain field wrong");
    a_volume_write: assert property (wr0 && regAddr == 8'h57 |-> ##2 sixthDigitalVolume == $past(regWdata, 2))
        else $error("volume field wrong");
    a_mute_flag: assert property (wr0 && regAddr == 8'h57 && regWdata == 8'h00 ##1 !wr0 |-> ##[1:2] sixthMuted)
        else $error("mute flag missing");
    a_agc_off: assert property (!sixthAutoGainEnable && $past(!sixthAutoGainEnable) |-> !sixthAgcMode)
        else $error("agc active while disabled");
    a_agc_on: assert property ((sixthAutoGainEnable && agcGlobalMode) [*3] |-> sixthAgcMode)
        else $error("agc idle while enabled");
    a_read_hit: assert property (regRead && map |=> regHit) else $error("mapped read without hit");
    a_read_miss: assert property (regRead && !map |=> !regHit && regRdata == 8'h00)
        else $error("unmapped read answered");
    a_hit_cause: assert property (regHit |-> $past(regRead) && $past(map)) else $error("hit without read");
    a_gain_bit0: assert property (regRead && map && regAddr == 8'h56 |=> !regRdata[0])
        else $error("gain bit 0 not zero");
    c_agc_set: cover property (wr0 && regAddr == 8'h55 && regWdata[0]);
    c_miss: cover property (regRead && !map);
    c_muted: cover property (sixthMuted);
endmodule
bind sixcfg_regs sixcfg_chk u_chk (.*);

/* sixcfg_host.sv */
// Host model: control software driving the byte register port.
// Assumes strobes are sampled on the rising core_clk edge.
module sixcfg_host (
    input  logic       core_clk,
    input  logic [7:0] regRdata,
    input  logic       regHit,
    output logic [7:0] regPage, regAddr, regWdata,
    output logic       regWrite, regRead
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {regPage, regAddr, regWdata, regWrite, regRead} = '0;
    // Callers hand only legal codes, AGC only with AC coupling
    task automatic wr(input logic [7:0] p, a, d);
        @(posedge core_clk) #1 {regPage, regAddr, regWdata, regWrite} = {p, a, d, 1'b1};
        @(posedge core_clk) #1 {regWdata, regWrite} = {~d, 1'b0};
    endtask
    // Read data is taken one edge after the strobe edge
    task automatic rd(input logic [7:0] p, a, output logic [7:0] d, output logic h);
        @(posedge core_clk) #1 {regPage, regAddr, regRead} = {p, a, 1'b1};
        @(posedge core_clk) #1 regRead = 1'b0;
        {d, h} = {regRdata, regHit};
    endtask
endmodule

/* tb_channel_six_config_regs.sv */
// Bench: table of writes and read-backs, then page, AGC and mid-run reset cases.
// Assumes the host model drives the port and the bound checker watches it.
module tb_channel_six_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, arst_n = 0, agcGlobalMode = 1, regWrite, regRead, regHit, h, sixthMuted, sixthAgcMode;
    logic sixthInputKind, sixthInputCoupling, sixthMicSwingRange, sixthAutoGainEnable;
    logic [1:0] sixthInputForm, sixthAmpPerfMode;
    logic [5:0] sixthAnalogGain;
    logic [7:0] regPage, regAddr, regWdata, regRdata, sixthDigitalVolume, d, cfg = 8'h10, gsh = 8'h00, vsh = 8'hC9;
    int err_total = 0, tests_run = 0, cyc = 0;
    // Address, write data, read-back, hit
    logic [24:0] rows [8] = '{{8'h55, 8'h18, 8'h18, 1'b1}, {8'h55, 8'hA5, 8'hA5, 1'b1}, {8'h56, 8'hAB, 8'hAA, 1'b1},
        {8'h56, 8'h01, 8'h00, 1'b1}, {8'h57, 8'h00, 8'h00, 1'b1}, {8'h57, 8'hFF, 8'hFF, 1'b1},
        {8'h57, 8'h01, 8'h01, 1'b1}, {8'h54, 8'h77, 8'h00, 1'b0}};
    sixcfg_regs uut (.*);
    sixcfg_host host (.*);
    always #2 core_clk = ~core_clk;
    // Hang guard, far above the roughly 60 cycles needed
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            final_report;
        end
    end
    task chk(string n, logic [7:0] e, g);
        tests_run++;
        if (e !== g) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Field outputs against the shadow copy
    task fld;
        chk("config", cfg, {sixthInputKind, sixthInputForm, sixthInputCoupling, sixthMicSwingRange,
            sixthAmpPerfMode, sixthAutoGainEnable});
        chk("gain", {2'b0, gsh[7:2]}, {2'b0, sixthAnalogGain});
        chk("volume", vsh, sixthDigitalVolume);
        chk("mute", {7'b0, vsh == 8'h00}, {7'b0, sixthMuted});
        chk("agc", {7'b0, cfg[0] & agcGlobalMode}, {7'b0, sixthAgcMode});
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Table loop, then wrong page with AGC global bit dropped, then reset in mid-run
    initial begin
        repeat (12) @(posedge core_clk);
        #1 arst_n = 1;
        repeat (4) @(posedge core_clk);
        foreach (rows[i]) begin
            host.wr(8'h00, rows[i][24:17], rows[i][16:9]);
            host.rd(8'h00, rows[i][24:17], d, h);
            chk("readback", rows[i][8:1], d);
            chk("hit", {7'b0, rows[i][0]}, {7'b0, h});
            case (rows[i][24:17])
                8'h55: cfg = rows[i][16:9];
                8'h56: gsh = rows[i][16:9] & 8'hFE;
                8'h57: vsh = rows[i][16:9];
            endcase
            fld;
            $display("row %0d done", i);
        end
        host.wr(8'h01, 8'h57, 8'h33);
        agcGlobalMode = 0;
        host.rd(8'h00, 8'h57, d, h);
        chk("page", vsh, d);
        fld;
        $display("page and agc test done");
        {arst_n, cfg, gsh, vsh} = {1'b0, 8'h10, 8'h00, 8'hC9};
        repeat (3) @(posedge core_clk);
        #1 arst_n = 1;
        repeat (4) @(posedge core_clk);
        fld;
        host.rd(8'h00, 8'h55, d, h);
        chk("reset config", 8'h10, d);
        $display("reset test done");
        final_report;
    end
endmodule
